//--- design/lin_mode_ctrl.sv
// LIN system-basis mode controller: modes, bus driver, wake, watchdog, reset
`timescale 1ns/1ps
module lin_mode_ctrl #(
    parameter int unsigned DOM_TIMEOUT_CYC  = lin_sbc_pkg::DOM_TIMEOUT_CYC,
    parameter int unsigned RESET_HOLD_CYC   = lin_sbc_pkg::RESET_HOLD_CYC,
    parameter int unsigned WAKE_FILT_CYC    = lin_sbc_pkg::WAKE_FILT_CYC,
    parameter int unsigned BUS_FILT_CYC     = lin_sbc_pkg::BUS_FILT_CYC,
    parameter int unsigned TRIG_MIN_CYC     = lin_sbc_pkg::TRIG_MIN_CYC,
    parameter int unsigned WDOG_WINDOW_CYC  = lin_sbc_pkg::WDOG_WINDOW_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic vs_present,
    input  wire logic vs_undervolt,
    input  wire logic vcc_undervolt,
    input  wire logic enable_in,
    input  wire logic txd_in,
    output logic      txd_out,
    output logic      txd_oe,
    input  wire logic lin_in,
    output logic      lin_out,
    output logic      lin_oe,
    output logic      rxd_out,
    output logic      rxd_oe,
    input  wire logic wake_n,
    input  wire logic ignition_in,
    input  wire logic wdog_disable,
    input  wire logic wdog_trigger_n,
    output logic      inhibit_out,
    output logic      reset_out_n_out,
    output logic      reset_out_n_oe,
    output logic      regulator_on,
    output logic [1:0] mode_out
);
    lin_sbc_pkg::op_mode_t  mode;
    lin_sbc_pkg::op_mode_t  next_mode;
    lin_sbc_pkg::wake_src_t wake_src;
    logic                   enable_prev;
    logic                   vs_prev;
    logic                   bus_wake_armed;
    logic                   ign_armed;
    logic                   wake_armed;
    logic                   dom_timed_out;
    logic [lin_sbc_pkg::CNT_W-1:0] dom_count;
    logic [lin_sbc_pkg::CNT_W-1:0] rel_count;
    logic [lin_sbc_pkg::CNT_W-1:0] hold_count;
    logic [lin_sbc_pkg::CNT_W-1:0] wdog_count;
    logic                   trig_qual_prev;
    logic                   wdog_fail;
    logic                   lin_prev;

    // Filters for wake pin, ignition, bus dominant and trigger pulse
    lin_filter_if wake_fif ();
    lin_filter_if ign_fif ();
    lin_filter_if bus_fif ();
    lin_filter_if trig_fif ();

    lin_level_filter #(.LEN(WAKE_FILT_CYC)) u_wake_filt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fif     (wake_fif)
    );
    lin_level_filter #(.LEN(lin_sbc_pkg::IGN_DEBOUNCE_CYC)) u_ign_filt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fif     (ign_fif)
    );
    lin_level_filter #(.LEN(BUS_FILT_CYC)) u_bus_filt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fif     (bus_fif)
    );
    lin_level_filter #(.LEN(TRIG_MIN_CYC)) u_trig_filt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fif     (trig_fif)
    );

    wire low_power   = (mode == lin_sbc_pkg::MODE_SLEEP) || (mode == lin_sbc_pkg::MODE_SILENT);
    wire powered     = vs_present && !rst;
    wire vs_rise     = vs_present && !vs_prev;
    wire hold_active = (hold_count != '0);
    // Reset output low on regulator undervoltage, watchdog failure or power-up hold
    wire reset_low   = vcc_undervolt || wdog_fail || hold_active;
    wire wdog_run    = !wdog_disable && !low_power;

    assign wake_fif.level  = !wake_n;
    assign wake_fif.enable = wake_armed;
    assign ign_fif.level   = ignition_in;
    assign ign_fif.enable  = ign_armed;
    assign bus_fif.level   = !lin_in;
    assign bus_fif.enable  = 1'b1;
    assign trig_fif.level  = !wdog_trigger_n;
    assign trig_fif.enable = wdog_run;

    // Wake qualifiers, each valid only from sleep or silent
    wire local_wake = low_power && wake_fif.qualified;
    wire ign_wake   = low_power && ign_fif.qualified;
    wire bus_wake   = low_power && bus_wake_armed && lin_in && !lin_prev;
    wire en_rise    = enable_in && !enable_prev;
    wire en_fall    = !enable_in && enable_prev;
    // Service counted once the low pulse has passed its minimum width
    wire trig_event = trig_fif.qualified && !trig_qual_prev;

    wire tx_path_on = (next_mode == lin_sbc_pkg::MODE_NORMAL) && !vs_undervolt
                      && !dom_timed_out;
    wire next_lin_drive = tx_path_on && !txd_in;

    always_comb begin
        next_mode = mode;
        case (mode)
            lin_sbc_pkg::MODE_FAILSAFE: begin
                if (enable_in && !hold_active) begin
                    next_mode = lin_sbc_pkg::MODE_NORMAL;
                end
            end
            lin_sbc_pkg::MODE_NORMAL: begin
                if (en_fall) begin
                    next_mode = txd_in ? lin_sbc_pkg::MODE_SILENT
                                       : lin_sbc_pkg::MODE_SLEEP;
                end
            end
            lin_sbc_pkg::MODE_SILENT, lin_sbc_pkg::MODE_SLEEP: begin
                if (en_rise) begin
                    next_mode = lin_sbc_pkg::MODE_NORMAL;
                end else if (local_wake || ign_wake || bus_wake || vs_undervolt) begin
                    next_mode = lin_sbc_pkg::MODE_FAILSAFE;
                end
            end
            default: begin
                next_mode = lin_sbc_pkg::MODE_FAILSAFE;
            end
        endcase
        if (reset_low || vs_rise) begin
            next_mode = lin_sbc_pkg::MODE_FAILSAFE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode <= lin_sbc_pkg::MODE_FAILSAFE;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_prev    <= 1'b0;
            vs_prev        <= 1'b0;
            lin_prev       <= 1'b1;
            trig_qual_prev <= 1'b0;
        end else begin
            enable_prev    <= enable_in;
            vs_prev        <= vs_present;
            lin_prev       <= lin_in;
            trig_qual_prev <= trig_fif.qualified;
        end
    end

    // Arming: local wake and ignition need release before a new request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_armed     <= 1'b0;
            ign_armed      <= 1'b0;
            bus_wake_armed <= 1'b0;
        end else begin
            if (wake_n) begin
                wake_armed <= 1'b1;
            end else if (local_wake) begin
                wake_armed <= 1'b0;
            end
            if (!ignition_in) begin
                ign_armed <= 1'b1;
            end else if (ign_wake) begin
                ign_armed <= 1'b0;
            end
            if (bus_fif.qualified) begin
                bus_wake_armed <= 1'b1;
            end else if (lin_in) begin
                bus_wake_armed <= 1'b0;
            end
        end
    end

    // Last wake source, shown on the transmit pin in fail-safe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_src <= lin_sbc_pkg::SRC_NONE;
        end else if (local_wake || ign_wake) begin
            wake_src <= lin_sbc_pkg::SRC_LOCAL;
        end else if (bus_wake) begin
            wake_src <= lin_sbc_pkg::SRC_BUS;
        end else if (mode == lin_sbc_pkg::MODE_NORMAL) begin
            wake_src <= lin_sbc_pkg::SRC_NONE;
        end
    end

    // Dominant timeout and release timer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dom_count     <= '0;
            rel_count     <= '0;
            dom_timed_out <= 1'b0;
        end else begin
            if (txd_in) begin
                dom_count <= '0;
            end else if (dom_count < lin_sbc_pkg::CNT_W'(DOM_TIMEOUT_CYC)) begin
                dom_count <= dom_count + 1'b1;
            end
            if (!txd_in) begin
                rel_count <= '0;
            end else if (rel_count < lin_sbc_pkg::CNT_W'(lin_sbc_pkg::TX_RELEASE_CYC)) begin
                rel_count <= rel_count + 1'b1;
            end
            if (!txd_in && dom_count >= lin_sbc_pkg::CNT_W'(DOM_TIMEOUT_CYC)) begin
                dom_timed_out <= 1'b1;
            end else if (rel_count >= lin_sbc_pkg::CNT_W'(lin_sbc_pkg::TX_RELEASE_CYC)) begin
                dom_timed_out <= 1'b0;
            end
        end
    end

    // Power-up reset hold and watchdog window
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_count <= '0;
            wdog_count <= '0;
            wdog_fail  <= 1'b0;
        end else begin
            if (vs_rise) begin
                hold_count <= lin_sbc_pkg::CNT_W'(RESET_HOLD_CYC);
            end else if (hold_active) begin
                hold_count <= hold_count - 1'b1;
            end
            if (!wdog_run || trig_event || wdog_fail) begin
                wdog_count <= '0;
            end else begin
                wdog_count <= wdog_count + 1'b1;
            end
            if (wdog_run && !wdog_fail
                    && wdog_count >= lin_sbc_pkg::CNT_W'(WDOG_WINDOW_CYC)) begin
                wdog_fail <= 1'b1;
            end else begin
                wdog_fail <= 1'b0;
            end
        end
    end

    // Registered pin outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lin_out         <= 1'b0;
            lin_oe          <= 1'b0;
            txd_out         <= 1'b0;
            txd_oe          <= 1'b0;
            rxd_out         <= 1'b0;
            rxd_oe          <= 1'b0;
            inhibit_out     <= 1'b0;
            reset_out_n_out <= 1'b0;
            reset_out_n_oe  <= 1'b1;
            regulator_on    <= 1'b0;
            mode_out        <= 2'h0;
        end else begin
            lin_out         <= 1'b0;
            lin_oe          <= next_lin_drive;
            txd_out         <= 1'b0;
            txd_oe          <= (next_mode == lin_sbc_pkg::MODE_FAILSAFE)
                               && (wake_src == lin_sbc_pkg::SRC_LOCAL || local_wake || ign_wake);
            rxd_oe          <= powered;
            if (next_mode == lin_sbc_pkg::MODE_NORMAL) begin
                rxd_out <= lin_in;
            end else if (next_mode == lin_sbc_pkg::MODE_FAILSAFE) begin
                rxd_out <= (wake_src == lin_sbc_pkg::SRC_NONE)
                           && !(local_wake || ign_wake || bus_wake);
            end else begin
                rxd_out <= (next_mode == lin_sbc_pkg::MODE_SILENT);
            end
            inhibit_out     <= !vcc_undervolt && !hold_active
                               && (next_mode == lin_sbc_pkg::MODE_NORMAL
                                   || next_mode == lin_sbc_pkg::MODE_FAILSAFE);
            reset_out_n_out <= 1'b0;
            reset_out_n_oe  <= reset_low;
            regulator_on    <= (next_mode != lin_sbc_pkg::MODE_SLEEP);
            mode_out        <= 2'(next_mode);
        end
    end

    // Checks on bus driver, reset, inhibit and receive outputs
    chk_drive_normal: assert property (
        @(posedge ref_clk) disable iff (rst) lin_oe |-> mode == lin_sbc_pkg::MODE_NORMAL)
        else $error("Bus driven outside normal mode");
    chk_uv_no_drive: assert property (
        @(posedge ref_clk) disable iff (rst) vs_undervolt |=> !lin_oe)
        else $error("Bus driven during supply undervoltage");
    chk_dom_timeout: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!txd_in && dom_count >= lin_sbc_pkg::CNT_W'(DOM_TIMEOUT_CYC)) |-> ##2 !lin_oe)
        else $error("Bus still driven after dominant timeout");
    chk_reset_low: assert property (
        @(posedge ref_clk) disable iff (rst) (vcc_undervolt || wdog_fail) |=> reset_out_n_oe)
        else $error("Reset output not pulled low");
    chk_reset_failsafe: assert property (
        @(posedge ref_clk) disable iff (rst)
        reset_out_n_oe |-> mode == lin_sbc_pkg::MODE_FAILSAFE)
        else $error("Reset low outside fail-safe mode");
    chk_inhibit_reset: assert property (
        @(posedge ref_clk) disable iff (rst) (vcc_undervolt || hold_active) |=> !inhibit_out)
        else $error("Inhibit on during undervoltage reset");
    chk_inhibit_low_power: assert property (
        @(posedge ref_clk) disable iff (rst) low_power |-> !inhibit_out)
        else $error("Inhibit on in sleep or silent mode");
    chk_sleep_regulator: assert property (
        @(posedge ref_clk) disable iff (rst) mode == lin_sbc_pkg::MODE_SLEEP |-> !regulator_on)
        else $error("Regulator on in sleep mode");
    chk_rx_unpowered: assert property (
        @(posedge ref_clk) disable iff (rst) !vs_present |=> !rxd_oe)
        else $error("Receive output on while unpowered");

    cov_bus_wake: cover property (
        @(posedge ref_clk) disable iff (rst) bus_wake);
    cov_local_wake: cover property (
        @(posedge ref_clk) disable iff (rst) local_wake || ign_wake);
    cov_dom_timeout: cover property (
        @(posedge ref_clk) disable iff (rst) $rose(dom_timed_out));
    cov_wdog_fail: cover property (
        @(posedge ref_clk) disable iff (rst) wdog_fail);
endmodule : lin_mode_ctrl

//--- include/lin_sbc_pkg.sv
// Package with timing counts and mode encodings for the LIN mode controller
package lin_sbc_pkg;
    localparam int unsigned CLK_HZ              = 10_000_000;
    localparam int unsigned DOM_TIMEOUT_US      = 6000;
    localparam int unsigned DOM_TIMEOUT_CYC     = DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TX_RELEASE_US       = 10;
    localparam int unsigned TX_RELEASE_CYC      = TX_RELEASE_US * (CLK_HZ / 1_000_000) + 1;
    localparam int unsigned IGN_DEBOUNCE_US     = 160;
    localparam int unsigned IGN_DEBOUNCE_CYC    = IGN_DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RESET_HOLD_US       = 4000;
    localparam int unsigned RESET_HOLD_CYC      = RESET_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAKE_FILT_CYC       = 300;
    localparam int unsigned BUS_FILT_CYC        = 300;
    localparam int unsigned TRIG_MIN_CYC        = 20;
    localparam int unsigned WDOG_WINDOW_CYC     = 200_000;
    localparam int unsigned CNT_W               = 20;

    typedef enum logic [1:0] {
        MODE_FAILSAFE,
        MODE_NORMAL,
        MODE_SILENT,
        MODE_SLEEP
    } op_mode_t;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_BUS,
        SRC_LOCAL
    } wake_src_t;
endpackage : lin_sbc_pkg

//--- include/lin_filter_if.sv
// Interface carrying one filter's input, enable and qualified output
`timescale 1ns/1ps
interface lin_filter_if;
    logic level;
    logic enable;
    logic qualified;
    modport filter (input level, input enable, output qualified);
    modport user   (output level, output enable, input qualified);
endinterface : lin_filter_if

//--- design/lin_level_filter.sv
// Level filter: output goes high once the input has been high for LEN cycles
`timescale 1ns/1ps
module lin_level_filter #(
    parameter int unsigned LEN = 16
) (
    input  wire logic     ref_clk,
    input  wire logic     rst,
    lin_filter_if.filter  fif
);
    logic [lin_sbc_pkg::CNT_W-1:0] count;
    wire                           run_on = fif.enable && fif.level;
    wire                           done   = (count >= lin_sbc_pkg::CNT_W'(LEN));

    always_ff @(posedge ref_clk) begin
        if (rst || !run_on) begin
            count <= '0;
        end else if (!done) begin
            count <= count + 1'b1;
        end
    end

    assign fif.qualified = run_on && done;
endmodule : lin_level_filter

//--- dv/lin_far_side.sv
// Far-side model: host pins, watchdog service and wired LIN bus
`timescale 1ns/1ps
module lin_far_side #(
    parameter int unsigned PERIOD  = 40,
    parameter int unsigned LOW_LEN = 8
) (
    input  wire logic ref_clk,
    input  wire logic serve_en,
    input  wire logic host_txd,
    input  wire logic remote_dom,
    input  wire logic lin_oe,
    input  wire logic txd_oe,
    output logic      txd_pin,
    output logic      lin_level,
    output logic      trig_n
);
    int unsigned tick = 0;

    // Device pull-down wins over the host driver
    assign txd_pin   = txd_oe ? 1'h0 : host_txd;
    // Bus with pull-up, low while any node drives dominant
    assign lin_level = !(lin_oe || remote_dom);
    // Service pulses held low well past the minimum width
    always @(negedge ref_clk) begin
        tick   <= serve_en ? (tick + 1) % PERIOD : 0;
        trig_n <= !(serve_en && tick < LOW_LEN);
    end
endmodule : lin_far_side

//--- dv/tb_lin_transceiver_mode_control.sv
// Testbench for the LIN mode controller
`timescale 1ns/1ps
module tb_lin_transceiver_mode_control;
    localparam int unsigned DOM = 50;
    localparam int unsigned FLT = 10;
    logic       ref_clk = 1'h0;
    logic       rst = 1'h1;
    logic       vs_present = 1'h0, vs_undervolt = 1'h0, vcc_undervolt = 1'h0;
    logic       enable_in = 1'h0, host_txd = 1'h1, remote_dom = 1'h0;
    logic       wake_n = 1'h1, ignition_in = 1'h0, wdog_disable = 1'h0, serve_en = 1'h1;
    logic       txd_pin, txd_out, txd_oe, lin_level, lin_out, lin_oe, rxd_out, rxd_oe;
    logic       trig_n, inhibit_out, reset_out_n_out, reset_out_n_oe, regulator_on;
    logic [1:0] mode_out;
    int         failures = 0;
    int         cmp_count = 0;

    always #50 ref_clk = ~ref_clk;

    lin_mode_ctrl #(.DOM_TIMEOUT_CYC(DOM), .RESET_HOLD_CYC(20), .WAKE_FILT_CYC(FLT),
        .BUS_FILT_CYC(FLT), .TRIG_MIN_CYC(4), .WDOG_WINDOW_CYC(100)) dut (
        .ref_clk(ref_clk), .rst(rst), .vs_present(vs_present),
        .vs_undervolt(vs_undervolt), .vcc_undervolt(vcc_undervolt),
        .enable_in(enable_in), .txd_in(txd_pin), .txd_out(txd_out), .txd_oe(txd_oe),
        .lin_in(lin_level), .lin_out(lin_out), .lin_oe(lin_oe), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .wake_n(wake_n), .ignition_in(ignition_in),
        .wdog_disable(wdog_disable), .wdog_trigger_n(trig_n), .inhibit_out(inhibit_out),
        .reset_out_n_out(reset_out_n_out), .reset_out_n_oe(reset_out_n_oe),
        .regulator_on(regulator_on), .mode_out(mode_out));

    lin_far_side far (.ref_clk(ref_clk), .serve_en(serve_en), .host_txd(host_txd),
        .remote_dom(remote_dom), .lin_oe(lin_oe), .txd_oe(txd_oe), .txd_pin(txd_pin),
        .lin_level(lin_level), .trig_n(trig_n));

    task automatic check(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic wait_mode(input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && mode_out !== m; i++) @(negedge ref_clk);
        check(mode_out, m);
    endtask : wait_mode

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic t_power_up;
        vs_present = 1'h1;
        cyc(2);
        check(reset_out_n_oe, 2'h1);
        check(mode_out, 2'h0);
        check(regulator_on, 2'h1);
        check(inhibit_out, 2'h0);
        enable_in = 1'h1;
        cyc(5);
        check(mode_out, 2'h0);
        cyc(20);
        check(reset_out_n_oe, 2'h0);
        wait_mode(2'h1, 5);
        check(regulator_on, 2'h1);
        check(inhibit_out, 2'h1);
        check(rxd_oe, 2'h1);
        check({lin_out, txd_out}, 2'h0);
        check(reset_out_n_out, 2'h0);
    endtask : t_power_up

    task automatic t_normal_tx;
        host_txd = 1'h0;
        cyc(2);
        check(lin_oe, 2'h1);
        check(rxd_out, 2'h0);
        host_txd = 1'h1;
        cyc(2);
        check(lin_oe, 2'h0);
        check(rxd_out, 2'h1);
        remote_dom = 1'h1;
        cyc(2);
        check(rxd_out, 2'h0);
        remote_dom = 1'h0;
        vs_undervolt = 1'h1;
        host_txd = 1'h0;
        cyc(2);
        check(lin_oe, 2'h0);
        vs_undervolt = 1'h0;
        host_txd = 1'h1;
        cyc(2);
    endtask : t_normal_tx

    task automatic t_timeout;
        host_txd = 1'h0;
        cyc(DOM - 5);
        check(lin_oe, 2'h1);
        cyc(10);
        check(lin_oe, 2'h0);
        host_txd = 1'h1;
        cyc(5);
        host_txd = 1'h0;
        cyc(2);
        check(lin_oe, 2'h0);
        host_txd = 1'h1;
        cyc(110);
        host_txd = 1'h0;
        cyc(2);
        check(lin_oe, 2'h1);
        host_txd = 1'h1;
        cyc(2);
    endtask : t_timeout

    task automatic t_silent_bus_wake;
        enable_in = 1'h0;
        cyc(2);
        check(mode_out, 2'h2);
        check(regulator_on, 2'h1);
        check(inhibit_out, 2'h0);
        remote_dom = 1'h1;
        cyc(FLT + 5);
        remote_dom = 1'h0;
        cyc(2);
        check(mode_out, 2'h0);
        check(rxd_out, 2'h0);
        check(inhibit_out, 2'h1);
        enable_in = 1'h1;
        wait_mode(2'h1, 5);
        enable_in = 1'h0;
        cyc(2);
        enable_in = 1'h1;
        wait_mode(2'h1, 3);
    endtask : t_silent_bus_wake

    task automatic t_sleep_wakes;
        host_txd = 1'h0;
        enable_in = 1'h0;
        cyc(2);
        host_txd = 1'h1;
        check(mode_out, 2'h3);
        check(regulator_on, 2'h0);
        check(inhibit_out, 2'h0);
        ignition_in = 1'h1;
        cyc(100);
        ignition_in = 1'h0;
        cyc(2600);
        check(mode_out, 2'h3);
        ignition_in = 1'h1;
        wait_mode(2'h0, 1700);
        cyc(2);
        check(txd_oe, 2'h1);
        enable_in = 1'h1;
        wait_mode(2'h1, 5);
        host_txd = 1'h0;
        enable_in = 1'h0;
        cyc(2);
        host_txd = 1'h1;
        check(mode_out, 2'h3);
        wake_n = 1'h0;
        wait_mode(2'h0, FLT + 5);
        cyc(2);
        check(txd_oe, 2'h1);
        wake_n = 1'h1;
        ignition_in = 1'h0;
        enable_in = 1'h1;
        wait_mode(2'h1, 5);
    endtask : t_sleep_wakes

    task automatic t_reset_paths;
        vcc_undervolt = 1'h1;
        cyc(2);
        check(reset_out_n_oe, 2'h1);
        check(inhibit_out, 2'h0);
        wait_mode(2'h0, 3);
        vcc_undervolt = 1'h0;
        wait_mode(2'h1, 30);
        serve_en = 1'h0;
        wait_mode(2'h0, 150);
        serve_en = 1'h1;
        wait_mode(2'h1, 30);
        cyc(300);
        check(mode_out, 2'h1);
        wdog_disable = 1'h1;
        serve_en = 1'h0;
        cyc(300);
        check(mode_out, 2'h1);
        vs_present = 1'h0;
        cyc(2);
        check(rxd_oe, 2'h0);
    endtask : t_reset_paths

    initial begin
        cyc(4);
        rst = 1'h0;
        cyc(1);
        t_power_up();
        t_normal_tx();
        t_timeout();
        t_silent_bus_wake();
        t_sleep_wakes();
        t_reset_paths();
        end_sim();
    end

    initial begin
        #2_000_000;
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule : tb_lin_transceiver_mode_control
